// *** rgbp_pkg.sv ***
// Package: timing and power sequencing constants for the RGB panel host controller
package rgbp_pkg;
  // System clock
  localparam int MCLK_HZ = 10000000;
  // Pixel clock toggles every PIXDIV mclk edges, so it runs at mclk / (2 * PIXDIV)
  // Limitation: a 10 MHz mclk gives 5 MHz, under the panel's 8 MHz floor
  localparam int PIXDIV = 1;
  // Horizontal timing in pixel clocks
  localparam int H_ACTIVE = 480;
  localparam int H_BACK = 43;
  localparam int H_FRONT = 8;
  localparam int H_SYNC = 4;
  localparam int H_TOTAL = H_SYNC + H_BACK + H_ACTIVE + H_FRONT;
  // Vertical timing in lines
  localparam int V_ACTIVE = 272;
  localparam int V_BACK = 12;
  localparam int V_FRONT = 8;
  localparam int V_SYNC = 4;
  localparam int V_TOTAL = V_SYNC + V_BACK + V_ACTIVE + V_FRONT;
  // Power sequencing times in ms and derived cycle counts (MCLK_HZ / 1000 truncates, no rounding up)
  localparam int T_RST_TO_STBY_MS = 10;
  localparam int T_VIDEO_TO_BL_MS = 250;
  localparam int T_BL_TO_STBY_MS = 5;
  localparam int T_DISCHARGE_MS = 80;
  localparam int RST_TO_STBY_CYC = T_RST_TO_STBY_MS * (MCLK_HZ / 1000);
  localparam int VIDEO_TO_BL_CYC = T_VIDEO_TO_BL_MS * (MCLK_HZ / 1000);
  localparam int BL_TO_STBY_CYC = T_BL_TO_STBY_MS * (MCLK_HZ / 1000);
  localparam int DISCHARGE_CYC = T_DISCHARGE_MS * (MCLK_HZ / 1000);
  // Mode encoding
  localparam logic [1:0] MODE_SYNC_DE = 2'h0;
  localparam logic [1:0] MODE_SYNC = 2'h1;
  localparam logic [1:0] MODE_DE = 2'h2;
  // FIFO geometry
  localparam int FIFO_W = 24;
  localparam int FIFO_D = 32;
  // Power sequencer states
  typedef enum logic [2:0] {
    PS_OFF, PS_RESET_WAIT, PS_VIDEO_WAIT, PS_ON, PS_BL_OFF_WAIT, PS_DISCHARGE
  } rgbp_pwr_e;
endpackage

// *** rgbp_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module rgbp_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input wire logic mclk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic [WIDTH-1:0] in_data, // Write data
  input wire logic in_valid, // Write valid
  output logic in_ready, // Not full
  output logic [WIDTH-1:0] out_data, // Read data
  output logic out_valid, // Not empty
  input wire logic out_ready // Reader takes word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Handshake terms
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // Storage write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
        count <= (AW+1)'(count + 1'b1);
      end else if (pop && !push) begin
        count <= (AW+1)'(count - 1'b1);
      end
    end
  end
endmodule

// *** rgbp_host.sv ***
// Host-side RGB panel timing generator and power sequencer
// Summary of operation
// - Three modes: sync+enable, sync only, enable only
// - Pixel clock between 8 and 12 MHz; here mclk / 2, so 5 MHz from the 10 MHz mclk
// - 480 active pixels, 272 active lines
// - Line 485..598 clocks, porch/pulse limits
// - Frame 276..321 lines, porch/pulse limits
// - Sync-only mode: back porches 43 and 12
// - Reset release allowed once supply stable
// - Standby high at least 10 ms after reset
// - Backlight on 250 ms after video starts
// - Backlight off, standby low 5 ms later
// - 80 ms discharge before power removal
`timescale 1ns/1ps
module rgbp_host #(
  parameter int RST_TO_STBY = rgbp_pkg::RST_TO_STBY_CYC, // Reset to standby-high cycles
  parameter int VIDEO_TO_BL = rgbp_pkg::VIDEO_TO_BL_CYC, // Video to backlight cycles
  parameter int BL_TO_STBY = rgbp_pkg::BL_TO_STBY_CYC, // Backlight off to standby-low
  parameter int DISCHARGE = rgbp_pkg::DISCHARGE_CYC // Discharge wait cycles
) (
  input wire logic mclk, // 10 MHz system clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic [1:0] mode, // Sync/enable mode select
  input wire logic power_up, // Level: request panel on
  output logic power_ok, // Panel sequence complete; power may be removed only when it and power_busy are both low
  output logic power_busy, // Sequencer in a wait state
  input wire logic [rgbp_pkg::FIFO_W-1:0] pix_data, // Pixel word in
  input wire logic pix_valid, // Pixel word valid
  output logic pix_ready, // FIFO can take a word
  output logic underrun, // Pulse: active pixel with empty FIFO
  output logic frame_start, // Pulse: start of frame
  output logic pixel_clock, // Pixel clock to panel
  output logic hsync_n, // Horizontal sync, active low
  output logic vsync_n, // Vertical sync, active low
  output logic active_pixel_strobe, // Data enable to panel
  output logic [7:0] red_bits, // Red data
  output logic [7:0] green_bits, // Green data
  output logic [7:0] blue_bits, // Blue data
  output logic panel_reset, // Panel reset, high releases
  output logic standby_control, // High normal, low standby
  output logic backlight_on // Backlight supply switch
);
  import rgbp_pkg::*;

  rgbp_pwr_e state;
  logic [31:0] wait_cnt;
  logic video_run;
  logic [9:0] hcnt;
  logic [8:0] vcnt;
  logic pclk_phase;
  logic pix_edge;
  logic h_act;
  logic v_act;
  logic act;
  logic [FIFO_W-1:0] f_data;
  logic f_valid;
  logic f_pop;

  // Pixel FIFO; pops only on an active pixel so the source stalls when it fills
  rgbp_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .mclk(mclk),
    .srst(srst),
    .in_data(pix_data),
    .in_valid(pix_valid),
    .in_ready(pix_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_pop)
  );

  // Pixel clock: mclk divided by two; the 8 MHz floor needs an mclk of 16 MHz or more,
  // a known limitation at 10 MHz; logic steps on the falling pixel edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      pclk_phase <= 1'b0;
    end else begin
      pclk_phase <= ~pclk_phase;
    end
  end
  assign pixel_clock = pclk_phase;
  assign pix_edge = pclk_phase; // Next mclk edge drops the pixel clock: update outputs then

  // Horizontal and vertical counters, fixed totals every line and frame
  always_ff @(posedge mclk) begin
    if (srst || !video_run) begin
      hcnt <= '0;
      vcnt <= '0;
    end else if (pix_edge) begin
      if (hcnt == 10'(H_TOTAL - 1)) begin
        hcnt <= '0;
        vcnt <= (vcnt == 9'(V_TOTAL - 1)) ? '0 : 9'(vcnt + 1'b1);
      end else begin
        hcnt <= 10'(hcnt + 1'b1);
      end
    end
  end

  // Active window placed after sync plus the fixed back porches
  assign h_act = (hcnt >= 10'(H_SYNC + H_BACK)) && (hcnt < 10'(H_SYNC + H_BACK + H_ACTIVE));
  assign v_act = (vcnt >= 9'(V_SYNC + V_BACK)) && (vcnt < 9'(V_SYNC + V_BACK + V_ACTIVE));
  assign act = video_run && h_act && v_act;
  assign f_pop = act && pix_edge;

  // Registered video outputs, changed only as the pixel clock falls
  // Stopping video idles the pins on a fall too, never under the panel's sampling edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      hsync_n <= 1'b1;
      vsync_n <= 1'b1;
      active_pixel_strobe <= 1'b0;
      red_bits <= 8'h00;
      green_bits <= 8'h00;
      blue_bits <= 8'h00;
    end else if (pix_edge && !video_run) begin
      hsync_n <= 1'b1;
      vsync_n <= 1'b1;
      active_pixel_strobe <= 1'b0;
      red_bits <= 8'h00;
      green_bits <= 8'h00;
      blue_bits <= 8'h00;
    end else if (pix_edge) begin
      // Grounded syncs in enable-only mode, grounded strobe in sync-only mode
      hsync_n <= (mode == MODE_DE) ? 1'b0 : !(hcnt < 10'(H_SYNC));
      vsync_n <= (mode == MODE_DE) ? 1'b0 : !(vcnt < 9'(V_SYNC));
      active_pixel_strobe <= (mode == MODE_SYNC) ? 1'b0 : act;
      // Data zero outside the active window
      if (act && f_valid) begin
        red_bits <= f_data[23:16];
        green_bits <= f_data[15:8];
        blue_bits <= f_data[7:0];
      end else begin
        red_bits <= 8'h00;
        green_bits <= 8'h00;
        blue_bits <= 8'h00;
      end
    end
  end

  // Event pulses
  always_ff @(posedge mclk) begin
    if (srst) begin
      underrun <= 1'b0;
      frame_start <= 1'b0;
    end else begin
      underrun <= f_pop && !f_valid;
      frame_start <= video_run && pix_edge && (hcnt == '0) && (vcnt == '0);
    end
  end

  // Power sequencer; each wait counts down a loaded cycle figure
  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= PS_OFF;
      wait_cnt <= '0;
      panel_reset <= 1'b0;
      standby_control <= 1'b0;
      backlight_on <= 1'b0;
      video_run <= 1'b0;
    end else begin
      case (state)
        PS_OFF: begin
          if (power_up) begin
            panel_reset <= 1'b1;
            wait_cnt <= 32'(RST_TO_STBY);
            state <= PS_RESET_WAIT;
          end
        end
        PS_RESET_WAIT: begin
          if (wait_cnt != '0) begin
            wait_cnt <= wait_cnt - 1'b1;
          end else begin
            standby_control <= 1'b1;
            video_run <= 1'b1;
            wait_cnt <= 32'(VIDEO_TO_BL);
            state <= PS_VIDEO_WAIT;
          end
        end
        PS_VIDEO_WAIT: begin
          if (!power_up) begin
            wait_cnt <= 32'(BL_TO_STBY);
            state <= PS_BL_OFF_WAIT;
          end else if (wait_cnt != '0) begin
            wait_cnt <= wait_cnt - 1'b1;
          end else begin
            backlight_on <= 1'b1;
            state <= PS_ON;
          end
        end
        PS_ON: begin
          if (!power_up) begin
            backlight_on <= 1'b0;
            wait_cnt <= 32'(BL_TO_STBY);
            state <= PS_BL_OFF_WAIT;
          end
        end
        PS_BL_OFF_WAIT: begin
          if (wait_cnt != '0) begin
            wait_cnt <= wait_cnt - 1'b1;
          end else begin
            standby_control <= 1'b0;
            video_run <= 1'b0;
            panel_reset <= 1'b0;
            wait_cnt <= 32'(DISCHARGE);
            state <= PS_DISCHARGE;
          end
        end
        default: begin
          if (wait_cnt != '0) begin
            wait_cnt <= wait_cnt - 1'b1;
          end else begin
            state <= PS_OFF;
          end
        end
      endcase
    end
  end

  assign power_ok = (state == PS_ON);
  assign power_busy = (state != PS_ON) && (state != PS_OFF);
endmodule

// *** rgbp_host_assertions.sv ***
// Checker: power ordering and video output relations of the host controller
`timescale 1ns/1ps
module rgbp_host_chk #(
  parameter int RST_TO_STBY = 20, // Reset to standby cycles
  parameter int VIDEO_TO_BL = 40, // Video to backlight cycles
  parameter int BL_TO_STBY = 10, // Backlight off to standby cycles
  parameter int DISCHARGE = 30 // Discharge cycles
) (
  input wire logic mclk, // Clock
  input wire logic srst, // Reset
  input wire logic [1:0] mode, // Mode select
  input wire logic power_busy, // Sequencer waiting
  input wire logic pixel_clock, // Pixel clock
  input wire logic active_pixel_strobe, // Data enable
  input wire logic [7:0] red_bits, // Red
  input wire logic [7:0] green_bits, // Green
  input wire logic [7:0] blue_bits, // Blue
  input wire logic panel_reset, // Reset release
  input wire logic standby_control, // Standby control
  input wire logic backlight_on // Backlight
);
  int c_rst, c_stb, c_bl, c_dis;
  // Time spent in each power level; c_rst and c_stb clear while low, c_bl and c_dis clear while high
  always_ff @(posedge mclk) begin
    c_rst <= (srst || !panel_reset) ? 0 : c_rst + 1;
    c_stb <= (srst || !standby_control) ? 0 : c_stb + 1;
    c_bl <= (srst || backlight_on) ? 0 : c_bl + 1;
    c_dis <= (srst || standby_control) ? 0 : c_dis + 1;
  end
  default clocking @(posedge mclk);
  endclocking
  default disable iff (srst);
  AST_STBY_WAIT: assert property ($rose(standby_control) |-> c_rst >= RST_TO_STBY)
    else $error("standby raised too early");
  AST_BL_WAIT: assert property ($rose(backlight_on) |-> c_stb >= VIDEO_TO_BL)
    else $error("backlight on too early");
  AST_BL_FIRST: assert property ($fell(standby_control) && !$past(srst) |->
    !backlight_on && c_bl >= BL_TO_STBY) else $error("standby dropped too early");
  AST_DISCHARGE: assert property ($fell(power_busy) && !standby_control && !$past(srst)
    |-> c_dis >= DISCHARGE) else $error("discharge wait too short");
  AST_BL_NEEDS_ON: assert property (backlight_on |-> standby_control && panel_reset)
    else $error("backlight on while panel not running");
  AST_SYNC_NO_STROBE: assert property (mode == rgbp_pkg::MODE_SYNC &&
    $past(mode, 3) == rgbp_pkg::MODE_SYNC |-> !active_pixel_strobe) else $error("strobe driven");
  AST_IDLE_ZERO: assert property (mode == rgbp_pkg::MODE_SYNC_DE && !active_pixel_strobe
    |-> {red_bits, green_bits, blue_bits} == 24'h0) else $error("data outside active");
  AST_DATA_ON_FALL: assert property (!$stable({red_bits, green_bits, blue_bits}) |->
    $fell(pixel_clock)) else $error("data moved off pixel clock fall");
  AST_PCLK_RUNS: assert property (standby_control && $past(standby_control, 3) |->
    pixel_clock != $past(pixel_clock)) else $error("pixel clock stalled");
endmodule
bind rgbp_host rgbp_host_chk #(.RST_TO_STBY(RST_TO_STBY), .VIDEO_TO_BL(VIDEO_TO_BL),
  .BL_TO_STBY(BL_TO_STBY), .DISCHARGE(DISCHARGE)) i_rgbp_host_chk (.mclk(mclk), .srst(srst),
  .mode(mode), .power_busy(power_busy), .pixel_clock(pixel_clock),
  .active_pixel_strobe(active_pixel_strobe), .red_bits(red_bits), .green_bits(green_bits),
  .blue_bits(blue_bits), .panel_reset(panel_reset), .standby_control(standby_control),
  .backlight_on(backlight_on));

// *** rgbp_panel_model.sv ***
// Behavioural panel: measures line timing and checks the pixel order
`timescale 1ns/1ps
module rgbp_panel_model (
  input wire logic pixel_clock, // Pixel clock
  input wire logic hsync_n, // Line sync
  input wire logic strobe, // Active pixel strobe
  input wire logic [23:0] pix, // Pixel bus
  input wire logic [1:0] mode, // Wiring strap
  input wire logic standby_control, // High runs panel
  input wire logic panel_reset, // High releases reset
  output int line_len, // Clocks in last line
  output int act_cnt, // Active pixels in last line
  output int act_off, // First active offset
  output int seq_err // Pixel order breaks
);
  import rgbp_pkg::*;
  int pc = 0;
  int ac = 0;
  int pos;
  logic prev_hs = 1'b1;
  logic prev_st = 1'b0;
  logic have = 1'b0;
  logic mark, act;
  logic [23:0] last;
  // Sync-only wiring finds pixels by counting, so the porch must be exact
  always @(posedge pixel_clock) begin
    if (panel_reset && standby_control) begin
      mark = (mode == MODE_DE) ? (strobe && !prev_st) : (!hsync_n && prev_hs);
      pos = mark ? 0 : pc;
      act = (mode == MODE_SYNC) ? (pos >= H_SYNC + H_BACK && pos < H_TOTAL - H_FRONT) : strobe;
      if (mark) begin
        line_len = pc;
        act_cnt = ac;
        ac = 0;
      end
      if (act) begin
        if (ac == 0) act_off = pos;
        if (have && pix !== last + 24'h1) seq_err++;
        ac++;
        have = 1'b1;
        last = pix;
      end
      pc = pos + 1;
      prev_hs = hsync_n;
      prev_st = strobe;
    end
  end
endmodule

// *** tb_top.sv ***
// Testbench: reset, buffer fill, power sequencing and line timing per mode
`timescale 1ns/1ps
module tb_top;
  import rgbp_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] mode = MODE_SYNC_DE;
  logic power_up = 1'b0;
  logic pix_valid = 1'b0;
  logic [23:0] pix_data = 24'h0;
  logic feed = 1'b0;
  logic took = 1'b0;
  logic bl_seen;
  logic fs_seen = 1'b0;
  logic ur_seen = 1'b0;
  wire logic power_ok, underrun, frame_start, vsync_n;
  wire logic power_busy, pix_ready, pixel_clock, hsync_n, strobe;
  wire logic panel_reset, standby_control, backlight_on;
  wire logic [7:0] red, green, blue;
  int err_count = 0;
  int checks = 0;
  int line_len, act_cnt, act_off, seq_err, base, n;
  rgbp_host #(.RST_TO_STBY(20), .VIDEO_TO_BL(40), .BL_TO_STBY(10), .DISCHARGE(30)) i_rgbp_host (
    .mclk(mclk), .srst(srst), .mode(mode), .power_up(power_up), .power_ok(power_ok),
    .power_busy(power_busy), .pix_data(pix_data), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .underrun(underrun), .frame_start(frame_start),
    .pixel_clock(pixel_clock),
    .hsync_n(hsync_n), .vsync_n(vsync_n), .active_pixel_strobe(strobe), .red_bits(red),
    .green_bits(green), .blue_bits(blue), .panel_reset(panel_reset),
    .standby_control(standby_control), .backlight_on(backlight_on));
  rgbp_panel_model i_rgbp_panel_model (.pixel_clock(pixel_clock), .hsync_n(hsync_n),
    .strobe(strobe), .pix({red, green, blue}), .mode(mode), .standby_control(standby_control),
    .panel_reset(panel_reset), .line_len(line_len), .act_cnt(act_cnt), .act_off(act_off),
    .seq_err(seq_err));
  initial begin
    forever #50 mclk = ~mclk;
  end
  // Next word only after the last was taken, so the stream counts up
  always @(posedge mclk) took <= pix_valid && pix_ready;
  // Feeder step plus sticky records of the one-cycle event pulses
  always @(negedge mclk) begin
    if (feed && took) pix_data <= pix_data + 24'h1;
    if (frame_start === 1'b1) fs_seen <= 1'b1;
    if (underrun === 1'b1) ur_seen <= 1'b1;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic test_fill();
    n = 0;
    pix_valid = 1'b1;
    repeat (40) begin
      @(negedge mclk);
      if (took) n++;
      if (took) pix_data = pix_data + 24'h1;
    end
    cmp(n, FIFO_D);
    cmp(pix_ready, 1'b0);
    feed = 1'b1;
    $display("test fill done");
  endtask
  task automatic test_power_on();
    power_up = 1'b1;
    for (int i = 0; i < 100 && standby_control !== 1'b1; i++) @(negedge mclk);
    cmp(panel_reset, 1'b1);
    cmp(backlight_on, 1'b0);
    for (int i = 0; i < 100 && backlight_on !== 1'b1; i++) @(negedge mclk);
    cmp(standby_control, 1'b1);
    cmp(power_ok, 1'b1);
    cmp(fs_seen, 1'b1);
    // Lines are measured inside the active rows, so wait out the vertical blanking
    for (int i = 0; i < 40 * H_TOTAL && strobe !== 1'b1; i++) @(negedge mclk);
    cmp(strobe, 1'b1);
    $display("test power on done");
  endtask
  task automatic test_lines(input logic [1:0] m);
    mode = m;
    repeat (6 * H_TOTAL) @(negedge mclk);
    base = seq_err;
    repeat (4 * H_TOTAL) @(negedge mclk);
    cmp(line_len, H_TOTAL);
    cmp(seq_err - base, 0);
    if (m != MODE_SYNC) cmp(act_cnt, H_ACTIVE);
    if (m == MODE_SYNC_DE) cmp(act_off, H_SYNC + H_BACK);
    if (m == MODE_SYNC) cmp(strobe, 1'b0);
    if (m == MODE_DE) cmp({hsync_n, vsync_n}, 2'h0);
    else cmp(vsync_n, 1'b1);
    cmp(ur_seen, 1'b0);
    $display("test lines mode %0d done", m);
  endtask
  task automatic test_power_off();
    power_up = 1'b0;
    for (int i = 0; i < 100 && standby_control !== 1'b0; i++) @(negedge mclk);
    cmp(backlight_on, 1'b0);
    for (int i = 0; i < 100 && power_busy !== 1'b0; i++) @(negedge mclk);
    cmp({panel_reset, standby_control, power_busy, power_ok}, 4'h0);
    $display("test power off done");
  endtask
  task automatic test_abort();
    bl_seen = 1'b0;
    power_up = 1'b1;
    for (int i = 0; i < 100 && standby_control !== 1'b1; i++) @(negedge mclk);
    power_up = 1'b0;
    for (int i = 0; i < 300 && (power_busy !== 1'b0 || i < 2); i++) begin
      @(negedge mclk);
      if (backlight_on !== 1'b0) bl_seen = 1'b1;
    end
    cmp({bl_seen, standby_control}, 2'h0);
    $display("test abort done");
  endtask
  initial begin
    repeat (6) @(negedge mclk);
    srst = 1'b0;
    cmp({panel_reset, standby_control, backlight_on, hsync_n, pix_ready}, 5'h03);
    test_fill();
    test_power_on();
    for (int m = 0; m < 3; m++) test_lines(2'(m));
    test_power_off();
    test_abort();
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge mclk);
    err_count++;
    tally_and_finish();
  end
endmodule
